// File: rtl/qm_dev.sv
// qm_dev: flash end of the quad mode control, clocked by the link clock
// assumes: mode 0 link, host drives sclk only while cs_n is low
// How it works
// - quad enable sits at bit 1 of status two
// - opcode 05h shifts out status one
// - opcode 35h shifts out status two
// - 01h plus two bytes writes quad enable
// - quad enable turns off hold and protect
// - mode byte Axh enters continuous read mode
// - mode byte 00h leaves continuous read mode
// - eight clocks of Fh force continuous exit
// - opcode 38h with quad enable enters 4-4-4
// - FFh or 66 then 99 leaves 4-4-4
// - status one bit 0 shows busy
`timescale 1ns/100ps
`include "qm_cfg.svh"
module qm_dev (
  // core clock and reset
  input  wire logic clk_i,
  input  wire logic nrst_i,
  // link
  qm_link_if.device lnk,
  // core side
  input  wire logic busy_i,
  output logic      quad_enable_bit_o,
  output logic      quad_cmd_mode_o,
  output logic      cont_read_o,
  output logic      hold_active_o,
  output logic      wp_active_o
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic byte_last(input logic wide,
                                     input logic [2:0] nbit);
    byte_last = wide ? (nbit == `QM_BIT_WIDE) : (nbit == `QM_BIT_NARROW);
  endfunction : byte_last

  function automatic logic [7:0] status_byte(input logic second,
                                             input logic busy,
                                             input logic qe);
    status_byte = `QM_SR_ZERO;
    if (second) begin
      status_byte[`QM_QE_BIT] = qe;
    end else begin
      status_byte[`QM_BUSY_BIT] = busy;
    end
  endfunction : status_byte

  // ----------------------------------------------------------------------
  // link domain state
  // ----------------------------------------------------------------------
  logic               quad_enable_bit;
  logic               quad_cmd_mode;
  logic               cont_read;
  logic               rst_armed;
  logic               busy_m;
  logic               busy_s;
  qm_pkg::qm_dphase_t ph;
  qm_pkg::qm_dphase_t cur_ph;
  logic [7:0]         sh;
  logic [2:0]         nbit;
  logic [2:0]         nbyte;
  logic               all_f;
  logic               rd_second;
  logic               wide;
  logic               last;
  logic               all_f_now;
  logic [7:0]         in_byte;
  logic [7:0]         out_byte;

  // first edge of a frame picks the phase from the remembered mode
  assign cur_ph = (ph == qm_pkg::QM_PH_START) ?
                  (cont_read ? qm_pkg::QM_PH_ADDR : qm_pkg::QM_PH_CMD) :
                  ph;
  assign wide = quad_cmd_mode || (cur_ph == qm_pkg::QM_PH_ADDR) ||
                (cur_ph == qm_pkg::QM_PH_DATA);
  assign last = byte_last(wide, nbit);
  assign in_byte = wide ? {sh[3:0], lnk.io} : {sh[6:0], lnk.io[0]};
  assign all_f_now = all_f && (lnk.io == `QM_ALL_F);

  // busy is a core level; sclk stops between frames so the view may lag
  always_ff @(posedge lnk.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      busy_m <= 1'b0;
      busy_s <= 1'b0;
    end else begin
      busy_m <= busy_i;
      busy_s <= busy_m;
    end
  end

  // ----------------------------------------------------------------------
  // mode bits that outlive a frame
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.sclk or negedge nrst_i) begin
    if (!nrst_i) begin
      quad_enable_bit <= 1'b0;
      quad_cmd_mode   <= 1'b0;
      cont_read       <= 1'b0;
      rst_armed       <= 1'b0;
    end else if (!lnk.cs_n && last) begin
      case (cur_ph)
        qm_pkg::QM_PH_CMD: begin
          rst_armed <= (in_byte == `QM_OP_RST_EN);
          case (in_byte)
            `QM_OP_QPI_EN: begin
              if (quad_enable_bit) begin
                quad_cmd_mode <= 1'b1;
              end
            end
            `QM_OP_QPI_EXIT: begin
              quad_cmd_mode <= 1'b0;
            end
            `QM_OP_RST: begin
              if (rst_armed) begin
                quad_cmd_mode <= 1'b0;
                cont_read     <= 1'b0;
              end
            end
            default: begin
            end
          endcase
        end
        qm_pkg::QM_PH_WDAT: begin
          if (nbyte == `QM_WR_LAST) begin
            quad_enable_bit <= in_byte[`QM_QE_BIT];
          end
        end
        qm_pkg::QM_PH_ADDR: begin
          if (nbyte == `QM_MODE_BYTE) begin
            if (cont_read && all_f_now) begin
              cont_read <= 1'b0;
            end else if (quad_enable_bit &&
                         in_byte[7:4] == `QM_MODE_HI) begin
              cont_read <= 1'b1;
            end else begin
              cont_read <= 1'b0;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // frame sequencing, cleared whenever chip select is high
  // ----------------------------------------------------------------------
  always_ff @(posedge lnk.sclk or negedge nrst_i or posedge lnk.cs_n) begin
    if (!nrst_i || lnk.cs_n) begin
      ph        <= qm_pkg::QM_PH_START;
      sh        <= `QM_SR_ZERO;
      nbit      <= 3'h0;
      nbyte     <= 3'h0;
      all_f     <= 1'b1;
      rd_second <= 1'b0;
    end else begin
      sh    <= in_byte;
      all_f <= all_f_now;
      ph    <= cur_ph;
      if (!last) begin
        nbit <= nbit + 3'h1;
      end else begin
        nbit  <= 3'h0;
        nbyte <= nbyte + 3'h1;
        case (cur_ph)
          qm_pkg::QM_PH_CMD: begin
            nbyte <= 3'h0;
            case (in_byte)
              `QM_OP_RDSR1: begin
                ph        <= qm_pkg::QM_PH_RDAT;
                rd_second <= 1'b0;
              end
              `QM_OP_RDSR2: begin
                ph        <= qm_pkg::QM_PH_RDAT;
                rd_second <= 1'b1;
              end
              `QM_OP_WRSR: begin
                ph <= qm_pkg::QM_PH_WDAT;
              end
              `QM_OP_QREAD: begin
                ph <= quad_enable_bit ? qm_pkg::QM_PH_ADDR :
                      qm_pkg::QM_PH_IGN;
              end
              default: begin
                ph <= qm_pkg::QM_PH_IGN;
              end
            endcase
          end
          qm_pkg::QM_PH_ADDR: begin
            if (nbyte == `QM_MODE_BYTE) begin
              // a forced exit carries no data
              ph <= (cont_read && all_f_now) ? qm_pkg::QM_PH_IGN :
                    qm_pkg::QM_PH_DATA;
            end
          end
          qm_pkg::QM_PH_WDAT: begin
            if (nbyte == `QM_WR_LAST) begin
              ph <= qm_pkg::QM_PH_IGN;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // output shifter, changes on the falling edge
  // ----------------------------------------------------------------------
  assign out_byte = (ph == qm_pkg::QM_PH_RDAT) ?
                    status_byte(rd_second, busy_s, quad_enable_bit) :
                    `QM_DATA_FILL;
  always_ff @(negedge lnk.sclk or negedge nrst_i or posedge lnk.cs_n) begin
    if (!nrst_i || lnk.cs_n) begin
      lnk.d_io_o  <= 4'h0;
      lnk.d_io_oe <= 4'h0;
    end else if (ph == qm_pkg::QM_PH_RDAT || ph == qm_pkg::QM_PH_DATA) begin
      if (wide) begin
        lnk.d_io_o  <= (nbit == 3'h0) ? out_byte[7:4] : out_byte[3:0];
        lnk.d_io_oe <= 4'hf;
      end else begin
        lnk.d_io_o  <= {2'b00, out_byte[3'd7 - nbit], 1'b0};
        lnk.d_io_oe <= 4'h2;
      end
    end else begin
      lnk.d_io_o  <= 4'h0;
      lnk.d_io_oe <= 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // core domain view: two-flop synchronisers for every level
  // ----------------------------------------------------------------------
  logic [2:0] mode_m;
  logic [1:0] pin_m;
  logic [1:0] pin_s;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mode_m            <= 3'h0;
      quad_enable_bit_o <= 1'b0;
      quad_cmd_mode_o   <= 1'b0;
      cont_read_o       <= 1'b0;
      pin_m             <= 2'b11;
      pin_s             <= 2'b11;
    end else begin
      mode_m            <= {quad_enable_bit, quad_cmd_mode, cont_read};
      quad_enable_bit_o <= mode_m[2];
      quad_cmd_mode_o   <= mode_m[1];
      cont_read_o       <= mode_m[0];
      pin_m             <= lnk.io[3:2];
      pin_s             <= pin_m;
    end
  end

  // hold and protect act only with quad enable clear and pin low
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_active_o <= 1'b0;
      wp_active_o   <= 1'b0;
    end else begin
      hold_active_o <= !quad_enable_bit_o && !pin_s[1];
      wp_active_o   <= !quad_enable_bit_o && !pin_s[0];
    end
  end

endmodule : qm_dev

// File: rtl/qm_cfg.svh
// qm_cfg.svh: opcodes, bit positions and counts for the quad mode control
// assumes: included by bare name from both link ends
`ifndef QM_CFG_SVH
`define QM_CFG_SVH

// ----------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------
`define QM_OP_RDSR1    8'h05
`define QM_OP_RDSR2    8'h35
`define QM_OP_WRSR     8'h01
`define QM_OP_QPI_EN   8'h38
`define QM_OP_QPI_EXIT 8'hff
`define QM_OP_RST_EN   8'h66
`define QM_OP_RST      8'h99
`define QM_OP_QREAD    8'heb

// ----------------------------------------------------------------------
// status fields and mode byte
// ----------------------------------------------------------------------
`define QM_BUSY_BIT    0
`define QM_QE_BIT      1
`define QM_SR_ZERO     8'h00
`define QM_MODE_HI     4'ha
`define QM_ALL_F       4'hf
`define QM_ALL_ONES    8'hff
`define QM_ADDR_ONES   24'hffffff

// ----------------------------------------------------------------------
// counts
// ----------------------------------------------------------------------
`define QM_BIT_NARROW  3'd7
`define QM_BIT_WIDE    3'd1
`define QM_MODE_BYTE   3'd3
`define QM_ADDR_LAST   3'd2
`define QM_WR_LAST     3'd1
`define QM_QRD_LAST    3'd3
`define QM_DATA_FILL   8'h3c
`define QM_SCLK_HALF   3'd3

`endif

// File: rtl/qm_pkg.sv
// qm_pkg: state and command types shared by both link ends
// assumes: qm_cfg.svh holds every number
package qm_pkg;

  typedef enum logic [2:0] {
    QM_PH_START = 3'b000,
    QM_PH_CMD   = 3'b001,
    QM_PH_ADDR  = 3'b010,
    QM_PH_WDAT  = 3'b011,
    QM_PH_RDAT  = 3'b100,
    QM_PH_DATA  = 3'b101,
    QM_PH_IGN   = 3'b110
  } qm_dphase_t;

  typedef enum logic [3:0] {
    QM_REQ_RDSR1    = 4'b0000,
    QM_REQ_RDSR2    = 4'b0001,
    QM_REQ_WRSR     = 4'b0010,
    QM_REQ_QPI_EN   = 4'b0011,
    QM_REQ_QPI_EXIT = 4'b0100,
    QM_REQ_RST_EN   = 4'b0101,
    QM_REQ_RST      = 4'b0110,
    QM_REQ_QREAD    = 4'b0111,
    QM_REQ_MODE_RST = 4'b1000
  } qm_req_t;

  typedef enum logic [2:0] {
    QM_H_IDLE = 3'b000,
    QM_H_CMD  = 3'b001,
    QM_H_ADDR = 3'b010,
    QM_H_WR   = 3'b011,
    QM_H_RD   = 3'b100,
    QM_H_END  = 3'b101
  } qm_hstate_t;

endpackage : qm_pkg

// File: rtl/qm_link_if.sv
// qm_link_if: serial clock, chip select and four shared data lines
// assumes: undriven data lines float high through a pull-up
`timescale 1ns/100ps
interface qm_link_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe;
  logic [3:0] io;

  // host wins a clash; no driver means pulled high
  assign io = (h_io_oe & h_io_o) | (~h_io_oe & d_io_oe & d_io_o)
            | (~h_io_oe & ~d_io_oe);

  modport host (output sclk, output cs_n, output h_io_o, output h_io_oe,
                input io);
  modport device (input sclk, input cs_n, input io, output d_io_o,
                  output d_io_oe);
endinterface : qm_link_if

// File: rtl/qm_host.sv
// qm_host: controller end, makes sclk and chip select from clk_i
// assumes: one request at a time, taken only while busy_o is low
`timescale 1ns/100ps
`include "qm_cfg.svh"
module qm_host (
  // clock and reset
  input  wire logic            clk_i,
  input  wire logic            nrst_i,
  // link
  qm_link_if.host              lnk,
  // requests
  input  wire logic            req_i,
  input  wire qm_pkg::qm_req_t op_i,
  input  wire logic [7:0]      wdata_i,
  input  wire logic [23:0]     addr_i,
  input  wire logic [7:0]      mode_i,
  // answers
  output logic                 busy_o,
  output logic                 done_o,
  output logic                 err_o,
  output logic [31:0]          rdata_o,
  output logic                 qe_o,
  output logic                 qpi_o,
  output logic                 cont_o
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  qm_pkg::qm_hstate_t st;
  qm_pkg::qm_req_t    op;
  logic [7:0]  tx;
  logic [7:0]  wd;
  logic [23:0] ad;
  logic [7:0]  md;
  logic [2:0]  nbit;
  logic [2:0]  nbyte;
  logic [2:0]  hc;
  logic        wide;
  logic        armed;
  logic [3:0]  io_m;
  logic [3:0]  io_s;
  logic        fall;
  logic        last;
  logic        refuse;

  assign fall = lnk.sclk && (hc == `QM_SCLK_HALF);
  assign last = wide ? (nbit == `QM_BIT_WIDE) : (nbit == `QM_BIT_NARROW);
  // quad work needs quad enable; continuous mode allows only reads/exit
  assign refuse = ((op_i == qm_pkg::QM_REQ_QPI_EN ||
                    op_i == qm_pkg::QM_REQ_QREAD) && !qe_o) ||
                  (cont_o && op_i != qm_pkg::QM_REQ_QREAD &&
                   op_i != qm_pkg::QM_REQ_MODE_RST);

  function automatic logic [7:0] opcode(input qm_pkg::qm_req_t r);
    case (r)
      qm_pkg::QM_REQ_RDSR1:    opcode = `QM_OP_RDSR1;
      qm_pkg::QM_REQ_RDSR2:    opcode = `QM_OP_RDSR2;
      qm_pkg::QM_REQ_WRSR:     opcode = `QM_OP_WRSR;
      qm_pkg::QM_REQ_QPI_EN:   opcode = `QM_OP_QPI_EN;
      qm_pkg::QM_REQ_RST_EN:   opcode = `QM_OP_RST_EN;
      qm_pkg::QM_REQ_RST:      opcode = `QM_OP_RST;
      qm_pkg::QM_REQ_QREAD:    opcode = `QM_OP_QREAD;
      default:                 opcode = `QM_OP_QPI_EXIT;
    endcase
  endfunction : opcode

  // ----------------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      io_m <= 4'hf;
      io_s <= 4'hf;
    end else begin
      io_m <= lnk.io;
      io_s <= io_m;
    end
  end

  // ----------------------------------------------------------------------
  // frame engine: outputs change and inputs are taken on the fall
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= qm_pkg::QM_H_IDLE;
      op <= qm_pkg::QM_REQ_RDSR1;
      {tx, wd, ad, md} <= 48'h0;
      {nbit, nbyte, hc} <= 9'h0;
      wide <= 1'b0;
      lnk.sclk <= 1'b0;
      lnk.cs_n <= 1'b1;
      rdata_o  <= 32'h0;
      {busy_o, done_o, err_o} <= 3'b000;
    end else begin
      done_o <= 1'b0;
      err_o  <= 1'b0;
      if (st != qm_pkg::QM_H_IDLE) begin
        hc <= (hc == `QM_SCLK_HALF) ? 3'h0 : hc + 3'h1;
      end
      case (st)
        qm_pkg::QM_H_IDLE: begin
          if (req_i && refuse) begin
            done_o <= 1'b1;
            err_o  <= 1'b1;
          end else if (req_i) begin
            op       <= op_i;
            wd       <= wdata_i;
            md       <= mode_i;
            busy_o   <= 1'b1;
            lnk.cs_n <= 1'b0;
            {nbit, nbyte, hc} <= 9'h0;
            rdata_o  <= 32'h0;
            if (op_i == qm_pkg::QM_REQ_MODE_RST) begin
              st   <= qm_pkg::QM_H_ADDR;
              tx   <= `QM_ALL_ONES;
              ad   <= `QM_ADDR_ONES;
              md   <= `QM_ALL_ONES;
              wide <= 1'b1;
            end else if (cont_o) begin
              st   <= qm_pkg::QM_H_ADDR;
              tx   <= addr_i[23:16];
              ad   <= addr_i;
              wide <= 1'b1;
            end else begin
              st   <= qm_pkg::QM_H_CMD;
              tx   <= opcode(op_i);
              ad   <= addr_i;
              wide <= qpi_o;
            end
          end
        end
        qm_pkg::QM_H_END: begin
          if (hc == `QM_SCLK_HALF) begin
            lnk.cs_n <= 1'b1;
            busy_o   <= 1'b0;
            done_o   <= 1'b1;
            st       <= qm_pkg::QM_H_IDLE;
          end
        end
        default: begin
          if (hc == `QM_SCLK_HALF) begin
            lnk.sclk <= !lnk.sclk;
          end
          if (fall) begin
            if (st == qm_pkg::QM_H_RD) begin
              rdata_o <= wide ? {rdata_o[27:0], io_s} :
                                {rdata_o[30:0], io_s[1]};
            end
            tx   <= wide ? {tx[3:0], 4'h0} : {tx[6:0], 1'b0};
            nbit <= nbit + 3'h1;
            if (last) begin
              nbit  <= 3'h0;
              nbyte <= nbyte + 3'h1;
              case (st)
                qm_pkg::QM_H_CMD: begin
                  nbyte <= 3'h0;
                  case (op)
                    qm_pkg::QM_REQ_RDSR1, qm_pkg::QM_REQ_RDSR2:
                      st <= qm_pkg::QM_H_RD;
                    qm_pkg::QM_REQ_WRSR: begin
                      st <= qm_pkg::QM_H_WR;
                      tx <= `QM_SR_ZERO;
                    end
                    qm_pkg::QM_REQ_QREAD: begin
                      st   <= qm_pkg::QM_H_ADDR;
                      tx   <= ad[23:16];
                      wide <= 1'b1;
                    end
                    default: st <= qm_pkg::QM_H_END;
                  endcase
                end
                qm_pkg::QM_H_ADDR: begin
                  case (nbyte)
                    3'h0: tx <= ad[15:8];
                    3'h1: tx <= ad[7:0];
                    `QM_ADDR_LAST: tx <= md;
                    default: begin
                      nbyte <= 3'h0;
                      st <= (op == qm_pkg::QM_REQ_MODE_RST) ?
                            qm_pkg::QM_H_END : qm_pkg::QM_H_RD;
                    end
                  endcase
                end
                qm_pkg::QM_H_WR: begin
                  tx <= wd;
                  if (nbyte == `QM_WR_LAST) begin
                    st <= qm_pkg::QM_H_END;
                  end
                end
                default: begin
                  if (!wide || nbyte == `QM_QRD_LAST) begin
                    st <= qm_pkg::QM_H_END;
                  end
                end
              endcase
            end
          end
        end
      endcase
    end
  end

  // data lines: drive while sending; keep protect and hold high when narrow
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lnk.h_io_o  <= 4'hf;
      lnk.h_io_oe <= 4'h0;
    end else if (st == qm_pkg::QM_H_CMD || st == qm_pkg::QM_H_ADDR ||
                 st == qm_pkg::QM_H_WR) begin
      lnk.h_io_o  <= wide ? tx[7:4] : {3'b110, tx[7]};
      lnk.h_io_oe <= wide ? 4'hf : 4'hd;
    end else begin
      lnk.h_io_o  <= 4'hf;
      lnk.h_io_oe <= qe_o ? 4'h0 : 4'hc;
    end
  end

  // ----------------------------------------------------------------------
  // host view of device modes, updated when a frame completes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {qe_o, qpi_o, cont_o, armed} <= 4'h0;
    end else if (st == qm_pkg::QM_H_END && hc == `QM_SCLK_HALF) begin
      armed <= (op == qm_pkg::QM_REQ_RST_EN);
      case (op)
        qm_pkg::QM_REQ_WRSR:     qe_o  <= wd[`QM_QE_BIT];
        qm_pkg::QM_REQ_QPI_EN:   qpi_o <= 1'b1;
        qm_pkg::QM_REQ_QPI_EXIT: qpi_o <= 1'b0;
        qm_pkg::QM_REQ_RST: begin
          if (armed) begin
            qpi_o  <= 1'b0;
            cont_o <= 1'b0;
          end
        end
        qm_pkg::QM_REQ_QREAD:
          cont_o <= (md[7:4] == `QM_MODE_HI);
        qm_pkg::QM_REQ_MODE_RST: cont_o <= 1'b0;
        default: begin
        end
      endcase
    end
  end

endmodule : qm_host

// File: dv/qm_link_checker.sv
// qm_link_checker: link framing and clock timing seen from clk_i
// assumes: instantiated beside qm_link_if, signals wired by name
`timescale 1ns/100ps
module qm_link_checker (
  // core clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // link signals
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] d_io_oe,
  // device core side levels
  input  wire logic       quad_enable_bit_i,
  input  wire logic       hold_active_i,
  input  wire logic       wp_active_i
);
  logic [7:0] beats;

  // a whole byte is 8 narrow or 2 wide beats, so frames count even
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i)
      beats <= 8'h00;
    else if (cs_n)
      beats <= 8'h00;
    else if ($rose(sclk))
      beats <= beats + 8'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  property p_idle_low; cs_n |-> !sclk; endproperty
  a_idle_low: assert property (p_idle_low)
    else $error("sclk high outside a frame");
  property p_dev_quiet; cs_n |-> d_io_oe == 4'h0; endproperty
  a_dev_quiet: assert property (p_dev_quiet)
    else $error("device drives outside a frame");
  property p_drive_low; $rose(|d_io_oe) |-> !sclk; endproperty
  a_drive_low: assert property (p_drive_low)
    else $error("device starts driving while sclk high");
  property p_high4; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high4: assert property (p_high4)
    else $error("sclk high phase not four cycles");
  property p_low4; $fell(sclk) |-> !sclk [*4]; endproperty
  a_low4: assert property (p_low4)
    else $error("sclk low phase too short");
  property p_gap; $rose(cs_n) |=> cs_n; endproperty
  a_gap: assert property (p_gap)
    else $error("chip select gap too short");
  property p_start; $fell(cs_n) |-> !sclk ##[1:8] sclk; endproperty
  a_start: assert property (p_start)
    else $error("first beat late or sclk high at select");
  property p_even; $rose(cs_n) |-> beats != 8'h00 && !beats[0]; endproperty
  a_even: assert property (p_even)
    else $error("frame not whole bytes");
  // quad frames pull the shared pins low, so a leak shows up here
  property p_pins_free; quad_enable_bit_i && $past(quad_enable_bit_i)
    |-> !hold_active_i && !wp_active_i; endproperty
  a_pins_free: assert property (p_pins_free)
    else $error("hold or protect active with quad enable set");
endmodule : qm_link_checker

// File: dv/tb_top.sv
// tb_top: both link ends joined, driven through the host request port
// assumes: host makes sclk from clk_i, so the bench makes no link clock
`timescale 1ns/100ps
module tb_top;
  logic            clk_i, nrst_i, req_i, busy_i, r_err;
  qm_pkg::qm_req_t op_i;
  logic [7:0]      wdata_i, mode_i, w;
  logic [23:0]     addr_i;
  logic            busy_o, done_o, err_o, qe_o, qpi_o, cont_o;
  logic [31:0]     rdata_o, r_dat;
  logic            quad_enable_bit_o, quad_cmd_mode_o, cont_read_o;
  logic            hold_active_o, wp_active_o;
  int              failures, num_checks, i;
  integer          seed;

  qm_link_if lnk();
  qm_host qm_host_inst(.clk_i, .nrst_i, .lnk(lnk), .req_i, .op_i,
    .wdata_i, .addr_i, .mode_i, .busy_o, .done_o, .err_o, .rdata_o,
    .qe_o, .qpi_o, .cont_o);
  qm_dev qm_dev_inst(.clk_i, .nrst_i, .lnk(lnk), .busy_i,
    .quad_enable_bit_o, .quad_cmd_mode_o, .cont_read_o, .hold_active_o,
    .wp_active_o);
  qm_link_checker qm_link_checker_inst(.clk_i, .nrst_i, .sclk(lnk.sclk),
    .cs_n(lnk.cs_n), .d_io_oe(lnk.d_io_oe),
    .quad_enable_bit_i(quad_enable_bit_o), .hold_active_i(hold_active_o),
    .wp_active_i(wp_active_o));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  function automatic logic [7:0] sr2(input logic qe);
    return {6'h00, qe, 1'b0};
  endfunction : sr2

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // one request, bounded wait for done, then time for the syncs
  task automatic run(input qm_pkg::qm_req_t op, input logic [7:0] m);
    int n;
    op_i    <= op;
    mode_i  <= m;
    wdata_i <= w;
    addr_i  <= 24'($random(seed));
    req_i   <= 1'b1;
    @(posedge clk_i);
    req_i <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (n == 2) chk(busy_o, 1'b1);
    end while (!done_o && n < 400);
    if (n == 400) begin
      failures++;
      report_and_stop();
    end
    chk(busy_o, 1'b0);
    r_err = err_o;
    r_dat = rdata_o;
    repeat (6) @(posedge clk_i);
  endtask : run

  initial begin
    seed = 32'hf5b536d4;
    failures = 0;
    num_checks = 0;
    {req_i, busy_i, wdata_i, mode_i, addr_i, w} = '0;
    op_i = qm_pkg::QM_REQ_RDSR1;
    nrst_i = 1'b0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    // busy is synced on sclk, so each level is read twice, second counted
    for (i = 0; i < 4; i++) begin
      busy_i <= i[1];
      run(qm_pkg::QM_REQ_RDSR1, 8'h00);
      if (i[0])
        chk(r_dat[7:0], {7'h00, i[1]});
    end
    run(qm_pkg::QM_REQ_QPI_EN, 8'h00);
    chk({r_err, quad_cmd_mode_o}, 2'b10);
    run(qm_pkg::QM_REQ_QREAD, 8'ha5);
    chk({r_err, cont_read_o}, 2'b10);
    for (i = 0; i < 4; i++) begin
      w = 8'($random(seed));
      w[1] = (i == 3) ? 1'b1 : w[1];
      run(qm_pkg::QM_REQ_WRSR, 8'h00);
      run(qm_pkg::QM_REQ_RDSR2, 8'h00);
      chk(r_dat[7:0], sr2(w[1]));
      chk(quad_enable_bit_o, w[1]);
      chk(qe_o, w[1]);
    end
    chk({hold_active_o, wp_active_o}, 2'b00);
    run(qm_pkg::QM_REQ_QREAD, 8'ha5);
    chk(r_dat, 32'h3c3c3c3c);
    chk({cont_o, cont_read_o}, 2'b11);
    run(qm_pkg::QM_REQ_RDSR1, 8'h00);
    chk(r_err, 1'b1);
    run(qm_pkg::QM_REQ_QREAD, 8'h00);
    chk(r_dat, 32'h3c3c3c3c);
    chk({cont_o, cont_read_o}, 2'b00);
    run(qm_pkg::QM_REQ_QREAD, {4'ha, 4'($random(seed))});
    chk({cont_o, cont_read_o}, 2'b11);
    run(qm_pkg::QM_REQ_MODE_RST, 8'h00);
    chk({cont_o, cont_read_o}, 2'b00);
    run(qm_pkg::QM_REQ_QPI_EN, 8'h00);
    chk({qpi_o, quad_cmd_mode_o}, 2'b11);
    run(qm_pkg::QM_REQ_RDSR2, 8'h00);
    chk(r_dat[7:0], sr2(1'b1));
    run(qm_pkg::QM_REQ_QPI_EXIT, 8'h00);
    chk({qpi_o, quad_cmd_mode_o}, 2'b00);
    run(qm_pkg::QM_REQ_QPI_EN, 8'h00);
    run(qm_pkg::QM_REQ_RST_EN, 8'h00);
    run(qm_pkg::QM_REQ_RST, 8'h00);
    chk({qpi_o, quad_cmd_mode_o, quad_enable_bit_o}, 3'b001);
    report_and_stop();
  end
endmodule : tb_top
